// [rtl/jdp_buf_if.sv]
// Word path between the debug port and its two-entry buffer
`default_nettype none
interface jdp_buf_if;
   import jdp_pkg::*;
   logic            in_valid;
   logic            in_ready;
   logic [DR_W-1:0] in_data;
   logic            out_valid;
   logic            out_ready;
   logic [DR_W-1:0] out_data;
   logic            full;
   modport src (output in_valid, output in_data, input in_ready, input full,
                input out_valid, input out_data, output out_ready);
   modport buf_side (input in_valid, input in_data, output in_ready, output full,
                     output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// [rtl/jdp_debug_port.sv]
// Test access port with serial shift paths, debug event strobe and word buffer
// Functional notes
// - TAP state follows mode select on clock rise
// - Data input bits captured on clock rise
// - Data output driven only in shift states
// - Data output changes only on clock fall
// - Test reset low resets controller asynchronously
// - System reset leaves port state alone
// - Debug event gives low pulse, then high
// - All test logic moves only on test clock, except the event strobe countdown and the word buffer with its output stage
`default_nettype none
module jdp_debug_port (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  tck_i,
   input  wire logic                  tms_i,
   input  wire logic                  tdi_i,
   input  wire logic                  trst_n_i,
   output logic                       tdo_o,
   output logic                       tdo_oe_o,
   output logic                       debug_event_out_n,
   input  wire logic [jdp_pkg::DR_W-1:0] capture_word_i,
   output logic [jdp_pkg::DR_W-1:0]   word_data_o,
   output logic                       word_valid_o,
   input  wire logic                  word_ready_i
);
   import jdp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: clock, mode and data pins pass two flops first; test reset does not
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       tck_last_reg;
   logic       tck_rise;
   logic       tck_fall;
   logic       tms_s;
   logic       tdi_s;

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= {1'b1, tdi_i, tms_i, tck_i};
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         tck_last_reg <= 1'b0;
      end else begin
         tck_last_reg <= sync2_reg[0];
      end
   end

   // A stopped test clock yields no edges, so the controller and shift paths below hold
   assign tck_rise = sync2_reg[0] && !tck_last_reg;
   assign tck_fall = !sync2_reg[0] && tck_last_reg;
   assign tms_s    = sync2_reg[1];
   assign tdi_s    = sync2_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // Controller
   function automatic jdp_tap_t tap_next(input jdp_tap_t s, input logic m);
      case (s)
         TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         default:    tap_next = TAP_RESET;
      endcase
   endfunction

   jdp_tap_t tap_reg;

   // System reset is deliberately not a term here, so a session survives it
   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         tap_reg <= TAP_RESET;
      end else if (tck_rise) begin
         tap_reg <= tap_next(tap_reg, tms_s);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction and data paths
   logic [IR_W-1:0] ir_sr_reg;
   logic [IR_W-1:0] ir_reg;
   logic [DR_W-1:0] dr_sr_reg;
   logic            byp_reg;
   logic            ovf_reg;
   logic            use_byp;
   logic            shift_out;
   jdp_buf_if       wbuf ();

   assign use_byp = (ir_reg != OP_DATA) && (ir_reg != OP_STATUS);

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         ir_sr_reg <= IR_CAPTURE;
         ir_reg    <= IR_RESET;
      end else if (tck_rise) begin
         case (tap_reg)
            TAP_RESET:  ir_reg    <= IR_RESET;
            TAP_CAP_IR: ir_sr_reg <= IR_CAPTURE;
            TAP_SH_IR:  ir_sr_reg <= {tdi_s, ir_sr_reg[IR_W-1:1]};
            TAP_UPD_IR: ir_reg    <= ir_sr_reg;
            default:    ir_sr_reg <= ir_sr_reg;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         dr_sr_reg <= 16'h0000;
         byp_reg   <= 1'b0;
      end else if (tck_rise) begin
         case (tap_reg)
            TAP_CAP_DR: begin
               byp_reg <= 1'b0;
               if (ir_reg == OP_STATUS) begin
                  dr_sr_reg              <= 16'h0000;
                  dr_sr_reg[ST_OVF_BIT]  <= ovf_reg;
                  dr_sr_reg[ST_FULL_BIT] <= wbuf.full;
               end else begin
                  dr_sr_reg <= capture_word_i;
               end
            end
            TAP_SH_DR: begin
               byp_reg   <= tdi_s;
               dr_sr_reg <= {tdi_s, dr_sr_reg[DR_W-1:1]};
            end
            default: byp_reg <= byp_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delivered words; the host polls the full bit since it cannot be stalled
   logic push_req;

   assign push_req       = tck_rise && (tap_reg == TAP_UPD_DR) && (ir_reg == OP_DATA);
   assign wbuf.in_valid  = push_req;
   assign wbuf.in_data   = dr_sr_reg;
   // Pop whenever the output stage loads, so a head word is never offered twice
   assign wbuf.out_ready = !word_valid_o || word_ready_i;

   jdp_word_buf u_buf (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .bus        (wbuf.buf_side)
   );

   // Overflow flag: a refused word is counted lost; reading status clears it
   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         ovf_reg <= 1'b0;
      end else if (push_req && !wbuf.in_ready) begin
         ovf_reg <= 1'b1;
      end else if (tck_rise && (tap_reg == TAP_CAP_DR) && (ir_reg == OP_STATUS)) begin
         ovf_reg <= 1'b0;
      end
   end

   // Registered user-side copy of the buffer head
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         word_valid_o <= 1'b0;
         word_data_o  <= 16'h0000;
      end else if (!word_valid_o || word_ready_i) begin
         word_valid_o <= wbuf.out_valid;
         word_data_o  <= wbuf.out_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output, moved on the falling edge only
   assign shift_out = (tap_reg == TAP_SH_IR) ? ir_sr_reg[0] :
                      (use_byp ? byp_reg : dr_sr_reg[0]);

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_o <= (tap_reg == TAP_SH_IR) || (tap_reg == TAP_SH_DR);
         tdo_o    <= shift_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debug event strobe
   logic [DE_CNT_W-1:0] de_cnt_reg;

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         de_cnt_reg <= 8'h00;
      end else if (tck_rise && (tap_reg == TAP_UPD_DR) && (ir_reg == OP_EVENT)) begin
         de_cnt_reg <= DE_CNT_W'(DE_PULSE_CYC);
      end else if (de_cnt_reg != 8'h00) begin
         de_cnt_reg <= de_cnt_reg - 8'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         debug_event_out_n <= 1'b1;
      end else begin
         debug_event_out_n <= (de_cnt_reg == 8'h00);
      end
   end
endmodule
`default_nettype wire

// [rtl/jdp_pkg.sv]
// Constants and types shared by the debug port and its word buffer
`default_nettype none
package jdp_pkg;
   localparam int unsigned IR_W           = 4;
   localparam int unsigned DR_W           = 16;
   localparam int unsigned CLK_PERIOD_NS  = 10;
   // Low time of the debug event strobe, in its own unit, then in cycles
   localparam int unsigned DE_PULSE_NS    = 100;
   localparam int unsigned DE_PULSE_CYC   = (DE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DE_CNT_W       = 8;
   localparam logic [IR_W-1:0] IR_RESET   = 4'hf;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] OP_DATA    = 4'h2;
   localparam logic [IR_W-1:0] OP_EVENT   = 4'h3;
   localparam logic [IR_W-1:0] OP_STATUS  = 4'h4;
   localparam logic [IR_W-1:0] OP_BYPASS  = 4'hf;
   localparam int unsigned ST_OVF_BIT     = 0;
   localparam int unsigned ST_FULL_BIT    = 1;

   typedef enum logic [3:0] {
      TAP_RESET   = 4'b1111, TAP_IDLE    = 4'b1100,
      TAP_SEL_DR  = 4'b0111, TAP_CAP_DR  = 4'b0110,
      TAP_SH_DR   = 4'b0010, TAP_EX1_DR  = 4'b0001,
      TAP_PAU_DR  = 4'b0011, TAP_EX2_DR  = 4'b0000,
      TAP_UPD_DR  = 4'b0101, TAP_SEL_IR  = 4'b0100,
      TAP_CAP_IR  = 4'b1110, TAP_SH_IR   = 4'b1010,
      TAP_EX1_IR  = 4'b1001, TAP_PAU_IR  = 4'b1011,
      TAP_EX2_IR  = 4'b1000, TAP_UPD_IR  = 4'b1101
   } jdp_tap_t;
endpackage
`default_nettype wire

// [rtl/jdp_word_buf.sv]
// Two-entry buffer for words delivered by the debug port
`default_nettype none
module jdp_word_buf (
   input  wire logic    core_clk_i,
   input  wire logic    rst_i,
   jdp_buf_if.buf_side  bus
);
   import jdp_pkg::*;

   logic [DR_W-1:0] mem_reg [2];
   logic            wr_ptr_reg;
   logic            rd_ptr_reg;
   logic [1:0]      cnt_reg;
   logic            push;
   logic            pop;

   assign bus.in_ready  = (cnt_reg != 2'h2);
   assign bus.full      = (cnt_reg == 2'h2);
   assign bus.out_valid = (cnt_reg != 2'h0);
   assign bus.out_data  = mem_reg[rd_ptr_reg];
   assign push = bus.in_valid && bus.in_ready;
   assign pop  = bus.out_valid && bus.out_ready;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= bus.in_data;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg    <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         case ({push, pop})
            2'b10:   cnt_reg <= cnt_reg + 2'h1;
            2'b01:   cnt_reg <= cnt_reg - 2'h1;
            default: cnt_reg <= cnt_reg;
         endcase
      end
   end
endmodule
`default_nettype wire

// [test/jdp_debug_port_props.sv]
// Assertions on the debug port pins and word output
`default_nettype none
module jdp_debug_port_props
   import jdp_pkg::*;
(
   input wire logic            core_clk_i,
   input wire logic            rst_i,
   input wire logic            tck_i,
   input wire logic            tms_i,
   input wire logic            tdi_i,
   input wire logic            trst_n_i,
   input wire logic            tdo_o,
   input wire logic            tdo_oe_o,
   input wire logic            debug_event_out_n,
   input wire logic [DR_W-1:0] capture_word_i,
   input wire logic [DR_W-1:0] word_data_o,
   input wire logic            word_valid_o,
   input wire logic            word_ready_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  tck_hist;
   int unsigned de_low;
   // Pin samples of the test clock, so edges can be placed in time
   always_ff @(posedge core_clk_i) tck_hist <= {tck_hist[6:0], tck_i};
   always_ff @(posedge core_clk_i) de_low <= debug_event_out_n ? 0 : de_low + 1;
   //////////////////////////////////////////////////////////////////////
   a_tdo_fall_only: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      $changed(tdo_o) |-> !tck_i && !tck_hist[0] && |tck_hist[7:2])
      else $error("serial output moved away from a test clock fall");
   a_oe_fall_only: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      $changed(tdo_oe_o) |-> !tck_i && !tck_hist[0] && |tck_hist[7:2])
      else $error("output enable moved away from a test clock fall");
   a_trst_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !trst_n_i |-> !tdo_oe_o && !tdo_o && debug_event_out_n)
      else $error("test reset did not clear the port");
   a_event_width: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      $rose(debug_event_out_n) |-> de_low == DE_PULSE_CYC)
      else $error("event pulse has the wrong width");
   a_event_cause: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      $fell(debug_event_out_n) |-> tck_i && tck_hist[0])
      else $error("event pulse started outside a test clock high phase");
   a_event_quiet: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      tck_hist == 8'h00 |-> !$fell(debug_event_out_n))
      else $error("event pulse started with the test clock stopped");
   a_word_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
      else $error("offered word changed before it was taken");
   a_valid_after_rst: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      rst_i |=> !word_valid_o && word_data_o == '0)
      else $error("system reset left a word offered");
   a_rst_keeps_tap: assert property (@(posedge core_clk_i) disable iff (!trst_n_i)
      rst_i && tck_hist == 8'h00 |=> $stable(tdo_oe_o) && $stable(tdo_o))
      else $error("system reset disturbed the test port");
endmodule
bind jdp_debug_port jdp_debug_port_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o),
   .tdo_oe_o(tdo_oe_o), .debug_event_out_n(debug_event_out_n),
   .capture_word_i(capture_word_i), .word_data_o(word_data_o),
   .word_valid_o(word_valid_o), .word_ready_i(word_ready_i));
`default_nettype wire

// [test/jdp_host.sv]
// Behavioural test-port host that drives the pins and shifts scans
`default_nettype none
module jdp_host (
   input  wire logic core_clk_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i,
   output var logic  tck_o,
   output var logic  tms_o,
   output var logic  tdi_o,
   output var logic  trst_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tck_o = 1'b0;  // Rests low between scans, the pin has a pull-down
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b0;
   end
   // One test clock period of 16 core cycles, output sampled at the rise
   task automatic step(input logic ms, input logic di, output logic so);
      @(posedge core_clk_i);
      tms_o <= ms;
      tdi_o <= di;
      repeat (7) @(posedge core_clk_i);
      tck_o <= 1'b1;
      so = tdo_oe_i ? tdo_i : 1'bx;  // An undriven line never reads as data
      repeat (8) @(posedge core_clk_i);
      tck_o <= 1'b0;
   endtask
   task automatic scan(input logic ir, input int n, input logic [15:0] d,
                       output logic [15:0] c);
      logic x;
      c = '0;
      step(1'b1, 1'b1, x);
      if (ir) begin
         step(1'b1, 1'b1, x);
      end
      step(1'b0, 1'b1, x);
      step(1'b0, 1'b1, x);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], c[i]);
      end
      step(1'b1, 1'b1, x);
      step(1'b0, 1'b1, x);
   endtask
   task automatic tap_reset(input int n);
      logic x;
      @(posedge core_clk_i);
      trst_n_o <= 1'b0;
      repeat (n) @(posedge core_clk_i);
      trst_n_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      step(1'b0, 1'b1, x);
   endtask
   // Wiggles mode and data with the test clock stopped
   task automatic noise(input int n, inout int seed);
      repeat (n) begin
         @(posedge core_clk_i);
         tms_o <= 1'($random(seed));
         tdi_o <= 1'($random(seed));
      end
   endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the debug port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import jdp_pkg::*;
   logic            core_clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            ready = 1'b0;
   logic [DR_W-1:0] cap_word = '0;
   logic            tck, tms, tdi, trst_n, tdo, tdo_oe, de_n, valid;
   logic [DR_W-1:0] wdata, c, d;
   logic [DR_W-1:0] exp_q[$];
   int              bad_count = 0, num_checks = 0, seed = 39, low_cnt = 0, width = 0;
   always #5 core_clk_i = ~core_clk_i;
   jdp_debug_port dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .debug_event_out_n(de_n),
      .capture_word_i(cap_word), .word_data_o(wdata), .word_valid_o(valid),
      .word_ready_i(ready));
   jdp_host host (.core_clk_i(core_clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
      .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
   //////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [DR_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [DR_W-1:0] status_exp(input logic ovf, full);
      status_exp = '0;
      status_exp[ST_OVF_BIT] = ovf;
      status_exp[ST_FULL_BIT] = full;
   endfunction
   // Bypass stage holds a captured zero ahead of the shifted data
   function automatic logic [DR_W-1:0] bypass_exp(input logic [DR_W-1:0] v);
      bypass_exp = {v[DR_W-2:0], 1'b0};
   endfunction
   // Receiver stalls at random while words are drained
   task automatic pop();
      logic [DR_W-1:0] e;
      e = exp_q.pop_front();
      for (int k = 0; k < 64; k++) begin
         @(posedge core_clk_i);
         if (valid && ready) begin
            check("word", wdata, e);
            return;
         end
         ready <= 1'($random(seed));
      end
      check("word wait", 16'h0, 16'h1);
   endtask
   always @(posedge core_clk_i) begin
      if (!de_n) begin
         low_cnt++;
      end else if (low_cnt != 0) begin
         width = low_cnt;
         low_cnt = 0;
      end
   end
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      host.tap_reset(2);
      check("oe idle", 16'(tdo_oe), '0);
      check("event idle", 16'(de_n), 16'h1);
      check("valid idle", 16'(valid), '0);
      host.scan(1'b1, IR_W, 16'(OP_DATA), c);
      check("ir capture", c, 16'(IR_CAPTURE));
      check("oe after scan", 16'(tdo_oe), '0);
      // Third push fills the output stage and both entries, the fourth is dropped
      for (int k = 0; k < 4; k++) begin
         cap_word <= (k == 0) ? 16'hffff : 16'($random(seed));
         d = (k == 3) ? 16'h0000 : 16'($random(seed));
         host.scan(1'b0, DR_W, d, c);
         check("dr capture", c, cap_word);
         if (k < 3) begin
            exp_q.push_back(d);
         end
      end
      host.scan(1'b1, IR_W, 16'(OP_STATUS), c);
      host.scan(1'b0, DR_W, '0, c);
      check("status", c, status_exp(1'b1, 1'b1));
      host.scan(1'b0, DR_W, '0, c);
      check("status again", c, status_exp(1'b0, 1'b1));
      repeat (3) pop();
      ready <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      check("drained", 16'(valid), '0);
      // Stall the receiver so the next word waits for pop
      ready <= 1'b0;
      host.scan(1'b1, IR_W, 16'(OP_DATA), c);
      // Let the test clock rest before the system reset pulse
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b1;
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      cap_word <= 16'h5a5a;
      d = 16'($random(seed));
      host.scan(1'b0, DR_W, d, c);
      check("kept ir", c, 16'h5a5a);
      exp_q.push_back(d);
      pop();
      host.scan(1'b1, IR_W, 16'(OP_EVENT), c);
      host.scan(1'b0, 1, 16'h0001, c);
      repeat (30) @(posedge core_clk_i);
      check("event width", 16'(width), 16'(DE_PULSE_CYC));
      host.noise(64, seed);
      check("still event", 16'(de_n), 16'h1);
      host.scan(1'b1, IR_W, 16'(OP_DATA), c);
      check("ir after noise", c, 16'(IR_CAPTURE));
      // Walk into Shift-DR, then abort with the test reset
      repeat (4) host.step(1'b0, 1'b1, c[0]);
      host.step(1'b1, 1'b1, c[0]);
      repeat (3) host.step(1'b0, 1'b1, c[0]);
      // A system reset in mid-shift must leave the port driving
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b1;
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      check("shift oe", 16'(tdo_oe), 16'h1);
      host.tap_reset(2);
      check("reset oe", 16'(tdo_oe), '0);
      d = 16'h00ff;
      host.scan(1'b0, DR_W, d, c);
      check("bypass", c, bypass_exp(d));
      close_out();
   end
   initial begin
      repeat (40000) @(posedge core_clk_i);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
